/* File: shared/deser_pkg.sv */
package deser_pkg;
    // deserialization factor and lane count defaults
    localparam int FACTOR = 8;
    localparam int LANES = 4;
    localparam int FIFO_DEPTH = 4;
    localparam int SLIP_W = $clog2(FACTOR);
    // reset values
    localparam logic [SLIP_W-1:0] SLIP_RESET = '0;
    localparam logic [SLIP_W-1:0] PHASE_RESET = '0;
    // slip to valid data, in parallel clock periods
    localparam int SLIP_SETTLE_WORDS = 2;

    typedef logic [LANES-1:0][FACTOR-1:0] lane_words_t;

    typedef struct packed {
        lane_words_t data;
        logic [LANES-1:0][SLIP_W-1:0] slip_pos;
    } rx_word_t;
endpackage : deser_pkg

/* File: hdl/word_fifo.sv */
`timescale 1ns/1ps
module word_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PW-1:0] wr_ptr_reg;
    logic [PW-1:0] rd_ptr_reg;
    logic [PW:0] count_reg;
    logic push;
    logic pop;

    function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
        ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
    endfunction : ptr_inc

    assign in_ready_o = (count_reg != (PW + 1)'(DEPTH));
    assign out_valid_o = (count_reg != '0);
    assign out_data_o = mem_reg[rd_ptr_reg];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always_ff @(posedge clk_sys_i) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data_i;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= ptr_inc(wr_ptr_reg);
            end
            if (pop) begin
                rd_ptr_reg <= ptr_inc(rd_ptr_reg);
            end
            if (push && !pop) begin
                count_reg <= count_reg + (PW + 1)'(1);
            end else if (pop && !push) begin
                count_reg <= count_reg - (PW + 1)'(1);
            end
        end
    end
endmodule : word_fifo

/* File: hdl/lvds_soft_deserializer_bitslip.sv */
`timescale 1ns/1ps
module lvds_soft_deserializer_bitslip #(
    parameter int FACTOR = deser_pkg::FACTOR,
    parameter int LANES = deser_pkg::LANES,
    parameter int FIFO_DEPTH = deser_pkg::FIFO_DEPTH
) (
    // clock and reset; clk_sys_i is the receive_fast_clock
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // serial lanes from the pins
    input wire logic [LANES-1:0] serial_i,
    // slip requests from core logic
    input wire logic slip_all_i,
    input wire logic [LANES-1:0] slip_lane_i,
    // parallel clock enable
    output logic load_strobe_o,
    // parallel word stream
    output logic word_valid_o,
    input wire logic word_ready_i,
    output deser_pkg::rx_word_t word_o,
    // word lost because the buffer was full
    output logic overrun_o
);
    import deser_pkg::*;

    localparam int SW = (FACTOR > 1) ? $clog2(FACTOR) : 1;
    localparam int WW = $bits(rx_word_t);

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    // the first flop may go metastable; only the second is read
    logic [LANES-1:0] serial_meta_reg;
    logic [LANES-1:0] serial_sync_reg;

    always_ff @(posedge clk_sys_i) begin
        serial_meta_reg <= serial_i;
        serial_sync_reg <= serial_meta_reg;
    end

    ////////////////////////////////////////////////////////////////////////
    // word phase counter and load strobe

    logic [SW-1:0] phase_reg;
    logic load;

    function automatic logic [SW-1:0] wrap_inc(input logic [SW-1:0] v);
        wrap_inc = (v == SW'(FACTOR - 1)) ? '0 : v + SW'(1);
    endfunction : wrap_inc

    // load marks the last bit of a word; the strobe output trails it by a cycle
    assign load = (phase_reg == SW'(FACTOR - 1));

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            phase_reg <= PHASE_RESET;
        end else begin
            phase_reg <= wrap_inc(phase_reg);
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            load_strobe_o <= 1'b0;
        end else begin
            load_strobe_o <= load;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // slip request detection

    logic slip_all_prev_reg;
    logic [LANES-1:0] slip_lane_prev_reg;
    logic slip_all_rise;
    logic [LANES-1:0] slip_lane_rise;
    logic [LANES-1:0] slip_take;

    // common request counts once per pulse
    assign slip_all_rise = slip_all_i && !slip_all_prev_reg;
    // lane request sampled on the parallel clock, edge only
    assign slip_lane_rise = load ? (slip_lane_i & ~slip_lane_prev_reg) : '0;

    // a common and a lane request on the same edge give a single slip
    always_comb begin
        slip_take = slip_lane_rise;
        if (slip_all_rise) begin
            slip_take = '1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            slip_all_prev_reg <= 1'b0;
        end else begin
            slip_all_prev_reg <= slip_all_i;
        end
    end

    // the lane request is only looked at on load cycles, so a pulse
    // shorter than one word period can be missed altogether
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            slip_lane_prev_reg <= '0;
        end else if (load) begin
            slip_lane_prev_reg <= slip_lane_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // per-lane realignment and word assembly

    logic [LANES-1:0][SW-1:0] slip_pos_reg;
    logic [LANES-1:0][FACTOR-1:0] delay_reg;
    logic [LANES-1:0][FACTOR-1:0] shift_reg;
    logic [LANES-1:0] tap;

    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            // tap k adds k+1 bits of latency ahead of the shifter
            assign tap[g] = delay_reg[g][slip_pos_reg[g]];

            always_ff @(posedge clk_sys_i) begin
                if (!reset_n_i) begin
                    slip_pos_reg[g] <= SLIP_RESET;
                end else if (slip_take[g]) begin
                    slip_pos_reg[g] <= wrap_inc(slip_pos_reg[g]);
                end
            end

            always_ff @(posedge clk_sys_i) begin
                if (!reset_n_i) begin
                    delay_reg[g] <= '0;
                end else begin
                    delay_reg[g] <= {delay_reg[g][FACTOR-2:0], serial_sync_reg[g]};
                end
            end

            // first received bit ends in the msb
            always_ff @(posedge clk_sys_i) begin
                if (!reset_n_i) begin
                    shift_reg[g] <= '0;
                end else begin
                    shift_reg[g] <= {shift_reg[g][FACTOR-2:0], tap[g]};
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // word buffer

    rx_word_t load_word;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [WW-1:0] fifo_out_data;
    logic out_take;

    // the output register is free, or its word leaves this cycle
    assign out_take = !word_valid_o || word_ready_i;

    // words straight after a slip are corrupt; the core discards them
    always_comb begin
        load_word.data = shift_reg;
        load_word.slip_pos = slip_pos_reg;
    end

    word_fifo #(
        .WIDTH(WW),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .in_valid_i(load),
        .in_ready_o(fifo_in_ready),
        .in_data_i(load_word),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(out_take),
        .out_data_o(fifo_out_data)
    );

    // output stage so every output comes from a flip-flop
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            word_valid_o <= 1'b0;
        end else if (out_take) begin
            word_valid_o <= fifo_out_valid;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            word_o <= '0;
        end else if (out_take && fifo_out_valid) begin
            word_o <= rx_word_t'(fifo_out_data);
        end
    end

    // the serial stream cannot stall, so a word that finds the buffer
    // full is dropped and flagged instead of pushing back
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            overrun_o <= 1'b0;
        end else begin
            overrun_o <= load && !fifo_in_ready;
        end
    end
endmodule : lvds_soft_deserializer_bitslip

/* File: dv/serial_source.sv */
`timescale 1ns/1ps
module serial_source (
    // clock
    input wire logic clk_sys_i,
    // serial lanes, lane l leads lane 0 by l bits
    output logic [deser_pkg::LANES-1:0] serial_o
);
    import deser_pkg::*;
    localparam logic [FACTOR-1:0] PATTERN = 8'h1d;
    int idx = 0;
    always @(posedge clk_sys_i) idx <= (idx + 1) % FACTOR;
    always_comb begin
        for (int l = 0; l < LANES; l++) serial_o[l] = PATTERN[FACTOR-1-(idx+l)%FACTOR];
    end
endmodule : serial_source

/* File: dv/deser_properties.sv */
`timescale 1ns/1ps
module deser_properties #(
    parameter int FACTOR = deser_pkg::FACTOR,
    parameter int LANES = deser_pkg::LANES,
    parameter int FIFO_DEPTH = deser_pkg::FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // watched ports
    input wire logic [LANES-1:0] serial_i,
    input wire logic slip_all_i,
    input wire logic [LANES-1:0] slip_lane_i,
    input wire logic load_strobe_o,
    input wire logic word_valid_o,
    input wire logic word_ready_i,
    input wire deser_pkg::rx_word_t word_o,
    input wire logic overrun_o
);
    import deser_pkg::*;
    localparam int PHI = FACTOR + 1;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);
    strobe_period_a: assert property (
        load_strobe_o |=> !load_strobe_o [*7] ##1 load_strobe_o) else $error("strobe period");
    first_strobe_a: assert property (
        $rose(reset_n_i) |-> ##[1:PHI] load_strobe_o) else $error("no first strobe");
    reset_quiet_a: assert property (disable iff (1'b0) !reset_n_i |=> !load_strobe_o
        && !word_valid_o && !overrun_o && word_o == '0) else $error("reset outputs");
    word_hold_a: assert property (
        word_valid_o && !word_ready_i |=> word_valid_o && $stable(word_o)) else $error("hold");
    valid_follow_a: assert property (
        load_strobe_o && !word_valid_o |-> ##[0:2] word_valid_o) else $error("no word");
    valid_drop_a: assert property (
        $fell(word_valid_o) |-> $past(word_ready_i)) else $error("word lost");
    overrun_load_a: assert property (
        overrun_o |-> load_strobe_o) else $error("overrun off load");
    overrun_full_a: assert property (
        overrun_o |-> word_valid_o) else $error("overrun while empty");
    cover property (overrun_o);
    cover property ($rose(slip_all_i));
    cover property ($rose(|slip_lane_i));
endmodule : deser_properties

bind lvds_soft_deserializer_bitslip deser_properties #(.FACTOR(FACTOR), .LANES(LANES),
    .FIFO_DEPTH(FIFO_DEPTH)) chk (.*);

/* File: dv/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    import deser_pkg::*;
    typedef logic [LANES-1:0][SLIP_W-1:0] slip_vec_t;
    logic clk_sys_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic slip_all_i = 1'b0;
    logic [LANES-1:0] slip_lane_i = '0;
    logic word_ready_i = 1'b1;
    logic [LANES-1:0] serial_i;
    logic load_strobe_o, word_valid_o, overrun_o;
    rx_word_t word_o;
    slip_vec_t exp_q[$];
    slip_vec_t slips = '0;
    slip_vec_t ev;
    logic [FACTOR-1:0] base = '0;
    logic hit = 1'b0;
    logic [15:0] rnd = 16'h58ef;
    int fails = 0;
    int num_checks = 0;
    int grabs = 0;
    int overruns = 0;
    int gap = 0;
    logic base_set = 1'b0;
    always #2 clk_sys_i = ~clk_sys_i;
    serial_source src (.clk_sys_i(clk_sys_i), .serial_o(serial_i));
    lvds_soft_deserializer_bitslip dut (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .serial_i(serial_i),
        .slip_all_i(slip_all_i),
        .slip_lane_i(slip_lane_i),
        .load_strobe_o(load_strobe_o),
        .word_valid_o(word_valid_o),
        .word_ready_i(word_ready_i),
        .word_o(word_o),
        .overrun_o(overrun_o)
    );
    ////////////////////////////////////////////////////////////////
    function automatic logic [FACTOR-1:0] ror(input logic [FACTOR-1:0] w, input int n);
        return (w >> n) | (w << (FACTOR - n));
    endfunction : ror
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : conclude
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask : tick
    // let corrupted words pass, then compare the next word taken
    task automatic grab();
        tick((SLIP_SETTLE_WORDS + 2) * FACTOR);
        exp_q.push_back(slips);
        grabs++;
        for (int i = 0; i < 200 && exp_q.size() > 0; i++) tick(1);
        if (exp_q.size() > 0) begin
            fails++;
            conclude();
        end
    endtask : grab
    task automatic lane_pulse(input int l, input int hi);
        slip_lane_i[l] = 1'b1;
        tick(hi * FACTOR);
        slip_lane_i[l] = 1'b0;
        tick(2 * FACTOR);
        slips[l] = slips[l] + 1'b1;
    endtask : lane_pulse
    task automatic all_pulse();
        slip_all_i = 1'b1;
        tick(1);
        slip_all_i = 1'b0;
        tick(3 * FACTOR);
        for (int l = 0; l < LANES; l++) slips[l] = slips[l] + 1'b1;
    endtask : all_pulse
    // common and lane request taken on the same load edge give one slip
    task automatic both_pulse();
        for (int i = 0; i < 2 * FACTOR && load_strobe_o !== 1'b1; i++) tick(1);
        if (load_strobe_o !== 1'b1) begin
            fails++;
            conclude();
        end
        tick(FACTOR - 1);
        slip_all_i = 1'b1;
        slip_lane_i[0] = 1'b1;
        tick(1);
        slip_all_i = 1'b0;
        tick(2 * FACTOR);
        slip_lane_i[0] = 1'b0;
        tick(2 * FACTOR);
        for (int l = 0; l < LANES; l++) slips[l] = slips[l] + 1'b1;
    endtask : both_pulse
    always @(posedge clk_sys_i) begin
        if (overrun_o === 1'b1) overruns++;
        if (load_strobe_o === 1'b1) begin
            if (gap > 0) check("strobe gap", 8'(FACTOR), 8'(gap));
            gap = 1;
        end else if (gap > 0) begin
            gap++;
        end
        if (word_valid_o === 1'b1 && word_ready_i && grabs > 0) begin
            grabs--;
            ev = exp_q.pop_front();
            if (!base_set) base = word_o.data[0];
            base_set = 1'b1;
            for (int l = 0; l < LANES; l++) begin
                check("slip_pos", 8'(ev[l]), 8'(word_o.slip_pos[l]));
                check("data", ror(base, (ev[l] + FACTOR - l) % FACTOR), word_o.data[l]);
            end
        end
    end
    initial begin
        tick(12);
        reset_n_i = 1'b1;
        grab();
        for (int r = 0; r < FACTOR; r++) hit |= ror(8'h1d, r) === base;
        check("pattern", 8'h01, 8'(hit));
        $display("test base done");
        for (int l = 1; l < LANES; l++) repeat (l) lane_pulse(l, l + 1);
        grab();
        $display("test lane slip done");
        repeat (5) all_pulse();
        grab();
        repeat (3) all_pulse();
        grab();
        both_pulse();
        grab();
        $display("test common slip done");
        for (int i = 0; i < 300; i++) begin
            rnd = lfsr(rnd);
            word_ready_i = rnd[0];
            tick(1);
        end
        word_ready_i = 1'b0;
        tick(8 * FACTOR);
        check("overrun", 8'h01, 8'(overruns > 0));
        word_ready_i = 1'b1;
        for (int i = 0; i < 100 && word_valid_o !== 1'b0; i++) tick(1);
        check("drained", 8'h00, 8'(word_valid_o));
        if (word_valid_o !== 1'b0) conclude();
        grab();
        $display("test buffer done");
        conclude();
    end
    initial begin
        #200000;
        fails++;
        conclude();
    end
endmodule : tb_top
